// file: design/tmr_pkg.sv
// constants, field layouts and carrier types of the auto-reload timer block
package tmr_pkg;

	// special function register addresses
	localparam logic [7:0] ADDR_CTRL  = 8'h91; // control and status
	localparam logic [7:0] ADDR_RLL   = 8'h92; // reload value low byte
	localparam logic [7:0] ADDR_RLH   = 8'h93; // reload value high byte
	localparam logic [7:0] ADDR_CNTL  = 8'h94; // counter low byte
	localparam logic [7:0] ADDR_CNTH  = 8'h95; // counter high byte

	// reset values
	localparam logic [7:0] RST_CTRL   = 8'h00; // control and status
	localparam logic [7:0] RST_RELOAD = 8'h00; // both reload bytes
	localparam logic [7:0] RST_COUNT  = 8'h00; // both counter bytes

	// counting constants
	localparam logic [7:0] BYTE_MAX   = 8'hFF; // value before a byte wraps
	localparam logic [7:0] BYTE_ONE   = 8'h01; // counting step
	localparam logic [3:0] DIV_LAST   = 4'hB;  // last state of divide by twelve
	localparam logic [3:0] DIV_ZERO   = 4'h0;  // first state of divider
	localparam logic [3:0] DIV_STEP   = 4'h1;  // divider step

	// capture trigger selection codes, external clock is div12 for every code
	typedef enum logic [1:0] {
		XSEL_DIV12_CMP  = 2'b00, // div12 clock, comparator trigger
		XSEL_ALT01      = 2'b01, // taken like code 00
		XSEL_DIV12_XOSC = 2'b10, // div12 clock, oscillator/8 trigger
		XSEL_ALT11      = 2'b11  // treated like code 10
	} tmr_xsel_t;

	// control and status register layout, bit 7 down to bit 0
	typedef struct packed {
		logic      hi_flag;   // high byte overflow flag
		logic      lo_flag;   // low byte overflow flag
		logic      lo_irq_en; // low byte interrupt enable
		logic      cap_en;    // capture enable
		logic      split;     // split mode enable
		logic      run;       // run control
		tmr_xsel_t xsel;      // capture trigger select, external clock is div12 for every code
	} tmr_ctrl_t;

	// register access request from the core
	typedef struct packed {
		logic       wr;    // write strobe, one cycle
		logic       rd;    // read strobe, one cycle
		logic [7:0] addr;  // register address
		logic [7:0] wdata; // write data
	} tmr_sfr_req_t;

endpackage

// file: design/tmr_timer.sv
// auto-reload timer with split mode, capture and overflow flags
module tmr_timer (
	input  wire logic               i_core_clk,               // system clock
	input  wire logic               i_reset,                  // synchronous reset
	input  wire tmr_pkg::tmr_sfr_req_t i_sfr,                 // register request
	output logic [7:0]              o_sfr_rdata,              // read data
	input  wire logic               i_timer_irq_enable,       // global timer irq enable
	input  wire logic               i_low_byte_clock_choice,  // 1: low byte on system clock
	input  wire logic               i_high_byte_clock_choice, // 1: high byte on system clock, split mode only
	input  wire logic               i_comparator1,            // comparator output, async
	input  wire logic               i_ext_osc_div8,           // oscillator / 8, async
	output logic                    o_irq_request             // interrupt request level
);
	import tmr_pkg::*;

	// registered state
	tmr_ctrl_t  ctrl_q, ctrl_d;       // control and status
	logic [7:0] rll_q, rll_d;         // reload value low byte
	logic [7:0] rlh_q, rlh_d;         // reload value high byte
	logic [7:0] cl_q, cl_d;           // counter low byte
	logic [7:0] ch_q, ch_d;           // counter high byte
	logic [3:0] div_q, div_d;         // divide-by-twelve state
	logic [7:0] rdata_q, rdata_d;     // read data register
	logic       irq_q, irq_d;         // interrupt request register
	logic       trig_prev_q, trig_prev_d; // last selected trigger level

	// synchroniser chains, first stage read only by second
	logic cmp_s1_q, cmp_s2_q;         // comparator chain
	logic xosc_s1_q, xosc_s2_q;       // oscillator chain

	// combinational helpers
	logic div_tick;                   // one cycle in twelve
	logic tick_l, tick_h;             // per-byte clock ticks
	logic run_l, run_h;               // byte advances this cycle
	logic lo_ovf, hi_ovf;             // byte wraps this cycle
	logic trig_sel;                   // selected capture trigger
	logic cap_edge;                   // capture event this cycle
	logic wr_ctrl, wr_rll, wr_rlh, wr_cl, wr_ch; // decoded writes

	// two flip-flop synchronisers for the external sources
	always_ff @(posedge i_core_clk) begin
		cmp_s1_q  <= i_comparator1;
		cmp_s2_q  <= cmp_s1_q;
		xosc_s1_q <= i_ext_osc_div8;
		xosc_s2_q <= xosc_s1_q;
	end

	// next-state logic for the whole timer
	always_comb begin
		ctrl_d      = ctrl_q;
		rll_d       = rll_q;
		rlh_d       = rlh_q;
		cl_d        = cl_q;
		ch_d        = ch_q;
		rdata_d     = rdata_q;
		// address decode
		wr_ctrl = i_sfr.wr && (i_sfr.addr == ADDR_CTRL);
		wr_rll  = i_sfr.wr && (i_sfr.addr == ADDR_RLL);
		wr_rlh  = i_sfr.wr && (i_sfr.addr == ADDR_RLH);
		wr_cl   = i_sfr.wr && (i_sfr.addr == ADDR_CNTL);
		wr_ch   = i_sfr.wr && (i_sfr.addr == ADDR_CNTH);
		// system clock divided by twelve is the external clock for every code
		div_tick = (div_q == DIV_LAST);
		div_d    = div_tick ? DIV_ZERO : (div_q + DIV_STEP);
		// one external clock shared, each byte picks it or the system clock
		tick_l = i_low_byte_clock_choice ? 1'b1 : div_tick;
		tick_h = i_high_byte_clock_choice ? 1'b1 : div_tick;
		// trigger: upper code bit picks oscillator, else comparator
		trig_sel    = ctrl_q.xsel[1] ? xosc_s2_q : cmp_s2_q;
		trig_prev_d = trig_sel;
		cap_edge    = ctrl_q.cap_en && trig_sel && !trig_prev_q;
		// low byte: always runs when split, gated by run otherwise
		if (ctrl_q.split) begin
			run_l = tick_l;
		end else begin
			run_l = ctrl_q.run && tick_l;
		end
		lo_ovf = run_l && (cl_q == BYTE_MAX);
		// high byte: own clock and run bit when split, carry otherwise
		if (ctrl_q.split) begin
			run_h = ctrl_q.run && tick_h;
		end else begin
			run_h = lo_ovf;
		end
		hi_ovf = run_h && (ch_q == BYTE_MAX);
		// counting and reload
		if (run_l) begin
			if (!lo_ovf) begin
				cl_d = cl_q + BYTE_ONE;
			end else if (ctrl_q.split || hi_ovf) begin
				cl_d = rll_q;
			end else begin
				cl_d = RST_COUNT;
			end
		end
		if (run_h) begin
			if (hi_ovf) begin
				ch_d = rlh_q;
			end else begin
				ch_d = ch_q + BYTE_ONE;
			end
		end
		// software writes; counter writes win over counting
		if (wr_ctrl) begin
			ctrl_d = tmr_ctrl_t'(i_sfr.wdata);
		end
		if (wr_rll) begin
			rll_d = i_sfr.wdata;
		end
		if (wr_rlh) begin
			rlh_d = i_sfr.wdata;
		end
		if (wr_cl) begin
			cl_d = i_sfr.wdata;
		end
		if (wr_ch) begin
			ch_d = i_sfr.wdata;
		end
		// hardware sets win over a software clear in the same cycle
		if (lo_ovf) begin
			ctrl_d.lo_flag = 1'b1;
		end
		if (hi_ovf) begin
			ctrl_d.hi_flag = 1'b1;
		end
		// capture copies the running count into the reload bytes
		if (cap_edge) begin
			rll_d          = cl_q;
			rlh_d          = ch_q;
			ctrl_d.hi_flag = 1'b1;
		end
		// request follows the flags that are enabled
		irq_d = i_timer_irq_enable &&
			(ctrl_d.hi_flag || (ctrl_d.lo_flag && ctrl_d.lo_irq_en));
		// read data, unmapped addresses read zero
		if (i_sfr.rd) begin
			case (i_sfr.addr)
				ADDR_CTRL: rdata_d = ctrl_q;
				ADDR_RLL:  rdata_d = rll_q;
				ADDR_RLH:  rdata_d = rlh_q;
				ADDR_CNTL: rdata_d = cl_q;
				ADDR_CNTH: rdata_d = ch_q;
				default:   rdata_d = 8'h00;
			endcase
		end
	end

	// state registers
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ctrl_q      <= tmr_ctrl_t'(RST_CTRL);
			rll_q       <= RST_RELOAD;
			rlh_q       <= RST_RELOAD;
			cl_q        <= RST_COUNT;
			ch_q        <= RST_COUNT;
			div_q       <= DIV_ZERO;
			rdata_q     <= 8'h00;
			irq_q       <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			rll_q       <= rll_d;
			rlh_q       <= rlh_d;
			cl_q        <= cl_d;
			ch_q        <= ch_d;
			div_q       <= div_d;
			rdata_q     <= rdata_d;
			irq_q       <= irq_d;
			trig_prev_q <= trig_prev_d;
		end
	end

	// outputs straight from flip-flops
	assign o_sfr_rdata   = rdata_q;
	assign o_irq_request = irq_q;

	// checks on the timer behaviour
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_lo_flag_set: assert property (lo_ovf |=> ctrl_q.lo_flag)
		else $error("low overflow did not set low flag");
	a_lo_flag_split: assert property ((lo_ovf && ctrl_q.split) |=> ctrl_q.lo_flag)
		else $error("split low overflow did not set low flag");
	a_lo_flag_sticky: assert property ((ctrl_q.lo_flag && !wr_ctrl) |=> ctrl_q.lo_flag)
		else $error("low flag cleared without software");
	a_lo_irq_raise: assert property ((ctrl_q.lo_flag && ctrl_q.lo_irq_en
		&& $past(i_timer_irq_enable)) |-> o_irq_request)
		else $error("low overflow interrupt missing");
	a_capture_copy: assert property ((cap_edge && !wr_cl)
		|=> (rll_q == $past(cl_q)) && (rlh_q == $past(ch_q)))
		else $error("capture did not copy count");
	a_wide_carry: assert property ((!ctrl_q.split && lo_ovf && !hi_ovf && !wr_cl
		&& !wr_ch) |=> (cl_q == 8'h00) && (ch_q == $past(ch_q) + BYTE_ONE))
		else $error("16-bit carry wrong");
	a_split_reload: assert property ((ctrl_q.split && hi_ovf && !wr_ch)
		|=> ch_q == $past(rlh_q))
		else $error("split high byte reload wrong");
	a_run_stop: assert property ((!ctrl_q.split && !ctrl_q.run && !wr_cl)
		|=> $stable(cl_q))
		else $error("stopped 16-bit timer advanced");
	a_split_high_gate: assert property ((ctrl_q.split && !ctrl_q.run && !wr_ch)
		|=> $stable(ch_q))
		else $error("split high byte ran while stopped");
	a_split_low_free: assert property ((ctrl_q.split && tick_l && cl_q != BYTE_MAX
		&& !wr_cl) |=> cl_q == $past(cl_q) + BYTE_ONE)
		else $error("split low byte did not count");
	a_shared_ext_clk: assert property ((ctrl_q.split && !i_low_byte_clock_choice
		&& !div_tick && !wr_cl) |=> $stable(cl_q))
		else $error("low byte counted off external clock");
	a_byte_clk_pick: assert property ((ctrl_q.split && i_high_byte_clock_choice
		&& ctrl_q.run && ch_q != BYTE_MAX && !wr_ch) |=> ch_q == $past(ch_q) + BYTE_ONE)
		else $error("high byte ignored system clock choice");
	a_sync_depth: assert property (cmp_s2_q == $past(i_comparator1, 2))
		else $error("comparator not two-stage synchronised");
	a_div_twelve: assert property (div_tick |-> ##12 div_tick)
		else $error("external clock not divide by twelve");
	a_cmp_trigger: assert property ((ctrl_q.xsel == XSEL_DIV12_CMP && ctrl_q.cap_en
		&& cmp_s2_q && !trig_prev_q) |-> cap_edge)
		else $error("comparator trigger missed");
	a_xosc_trigger: assert property ((ctrl_q.xsel == XSEL_DIV12_XOSC && ctrl_q.cap_en
		&& xosc_s2_q && !trig_prev_q) |-> cap_edge)
		else $error("oscillator trigger missed");
	a_rll_write: assert property ((wr_rll && !cap_edge) |=> rll_q == $past(i_sfr.wdata))
		else $error("low reload write lost");
	a_hi_flag_set: assert property (hi_ovf |=> ctrl_q.hi_flag)
		else $error("high overflow did not set high flag");
	a_rlh_write: assert property ((wr_rlh && !cap_edge) |=> rlh_q == $past(i_sfr.wdata))
		else $error("high reload write lost");
	a_wide_reload: assert property ((!ctrl_q.split && hi_ovf && !wr_cl && !wr_ch)
		|=> (cl_q == $past(rll_q)) && (ch_q == $past(rlh_q)))
		else $error("16-bit reload wrong");

	// flag, interrupt and capture side effects
	a_hi_flag_sticky: assert property ((ctrl_q.hi_flag && !wr_ctrl) |=> ctrl_q.hi_flag)
		else $error("high flag cleared without software");
	a_lo_wrap_only: assert property ((!ctrl_q.lo_flag && !wr_ctrl)
		|=> ctrl_q.lo_flag == $past(lo_ovf))
		else $error("low flag set without a low wrap");
	a_hi_wrap_only: assert property ((!ctrl_q.hi_flag && !wr_ctrl)
		|=> ctrl_q.hi_flag == ($past(hi_ovf) || $past(cap_edge)))
		else $error("high flag set without wrap or capture");
	a_irq_no_enable: assert property (!$past(i_timer_irq_enable) |-> !o_irq_request)
		else $error("interrupt raised while globally disabled");
	a_lo_irq_masked: assert property ((!ctrl_q.lo_irq_en && !ctrl_q.hi_flag)
		|-> !o_irq_request)
		else $error("masked low flag raised interrupt");
	a_cap_flag: assert property (cap_edge |=> ctrl_q.hi_flag)
		else $error("capture did not set high flag");
	a_cap_off: assert property (!ctrl_q.cap_en |-> !cap_edge)
		else $error("capture while capture disabled");
	a_ctrl_write: assert property ((wr_ctrl && !lo_ovf && !hi_ovf && !cap_edge)
		|=> ctrl_q == tmr_ctrl_t'($past(i_sfr.wdata)))
		else $error("control write lost");

	// counting, reload and synchroniser paths
	a_run_wide_count: assert property ((!ctrl_q.split && ctrl_q.run && tick_l
		&& cl_q != BYTE_MAX && !wr_cl) |=> cl_q == $past(cl_q) + BYTE_ONE)
		else $error("running 16-bit timer did not count");
	a_wide_high_hold: assert property ((!ctrl_q.split && !lo_ovf && !wr_ch)
		|=> $stable(ch_q))
		else $error("16-bit high byte moved without carry");
	a_split_low_reload: assert property ((ctrl_q.split && lo_ovf && !wr_cl)
		|=> cl_q == $past(rll_q))
		else $error("split low byte reload wrong");
	a_high_div_tick: assert property ((ctrl_q.split && !i_high_byte_clock_choice
		&& !div_tick && !wr_ch) |=> $stable(ch_q))
		else $error("high byte counted off external clock");
	a_div_range: assert property (div_q <= DIV_LAST)
		else $error("divider left its twelve states");
	a_xosc_sync: assert property (xosc_s2_q == $past(i_ext_osc_div8, 2))
		else $error("oscillator not two-stage synchronised");
	a_rll_hold: assert property ((!wr_rll && !cap_edge) |=> $stable(rll_q))
		else $error("low reload byte changed by itself");
	a_rlh_hold: assert property ((!wr_rlh && !cap_edge) |=> $stable(rlh_q))
		else $error("high reload byte changed by itself");
	a_low_count_write: assert property (wr_cl |=> cl_q == $past(i_sfr.wdata))
		else $error("low counter write lost");
	a_high_count_write: assert property (wr_ch |=> ch_q == $past(i_sfr.wdata))
		else $error("high counter write lost");

	// register reads and reset
	a_rd_hold: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
		else $error("read data changed without a read");
	a_rll_read: assert property ((i_sfr.rd && i_sfr.addr == ADDR_RLL)
		|=> o_sfr_rdata == $past(rll_q))
		else $error("low reload read wrong");
	a_rlh_read: assert property ((i_sfr.rd && i_sfr.addr == ADDR_RLH)
		|=> o_sfr_rdata == $past(rlh_q))
		else $error("high reload read wrong");
	a_ctrl_read: assert property ((i_sfr.rd && i_sfr.addr == ADDR_CTRL)
		|=> tmr_ctrl_t'(o_sfr_rdata) == $past(ctrl_q))
		else $error("control read wrong");
	a_unmapped_zero: assert property ((i_sfr.rd && (i_sfr.addr < ADDR_CTRL
		|| i_sfr.addr > ADDR_CNTH)) |=> o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	// this one must look through reset, so it overrides the default disable
	a_reset_quiet: assert property (disable iff (1'b0) i_reset
		|=> !o_irq_request && o_sfr_rdata == 8'h00 && cl_q == RST_COUNT && ch_q == RST_COUNT)
		else $error("outputs not cleared by reset");

endmodule

// file: tb/tmr_timer_tb.sv
// self-checking bench for the auto-reload timer block
module timer3_control_and_reload_low_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	logic         i_core_clk = 1'b0; // system clock
	logic         i_reset    = 1'b1; // synchronous reset
	tmr_sfr_req_t sfr        = '0;   // register request
	logic [7:0]   rdata;             // read data
	logic         irq_en     = 1'b1; // global irq enable
	logic         lo_sys     = 1'b1; // low byte on system clock
	logic         hi_sys     = 1'b1; // high byte on system clock
	logic         cmp1       = 1'b0; // comparator output
	logic         osc8       = 1'b0; // oscillator / 8
	logic         irq;               // interrupt request
	logic [7:0]   v;                 // last value read
	int           err_total       = 0;
	int           samples_checked = 0;
	int           cycles          = 0;

	tmr_timer uut (
		.i_core_clk              (i_core_clk),
		.i_reset                 (i_reset),
		.i_sfr                   (sfr),
		.o_sfr_rdata             (rdata),
		.i_timer_irq_enable      (irq_en),
		.i_low_byte_clock_choice (lo_sys),
		.i_high_byte_clock_choice(hi_sys),
		.i_comparator1           (cmp1),
		.i_ext_osc_div8          (osc8),
		.o_irq_request           (irq)
	);

	// free-running clock, 5 ns period
	always #2.5 i_core_clk = ~i_core_clk;

	// cuts a hang short
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			end_sim();
		end
	end

	// verdict and end of run
	task end_sim();
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// compares one byte
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, got, exp);
		end
	endtask

	// one register write, strobe held for one edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		sfr.wr    <= 1'b1;
		sfr.addr  <= a;
		sfr.wdata <= d;
		@(posedge i_core_clk);
		sfr.wr <= 1'b0;
	endtask

	// one register read; data lands at the edge that takes it
	task rd(input logic [7:0] a);
		@(posedge i_core_clk);
		sfr.rd   <= 1'b1;
		sfr.addr <= a;
		@(posedge i_core_clk);
		sfr.rd <= 1'b0;
		#1 v = rdata;
	endtask

	// waits n edges, then lets their updates settle
	task wait_cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	// reset values, unmapped neighbours too, then reload byte access
	task t_reset();
		for (int a = 'h90; a <= 'h96; a++) begin
			rd(8'(a));
			chk(v, 8'h00);
		end
		wr(ADDR_RLL, 8'hA5);
		rd(ADDR_RLL);
		chk(v, 8'hA5);
	endtask

	// 16-bit wrap from FFFE, sticky flags, irq gating, stop
	task t_wide();
		logic [7:0] s;
		wr(ADDR_RLL, 8'h34);
		wr(ADDR_RLH, 8'h12);
		wr(ADDR_CNTL, 8'hFE);
		wr(ADDR_CNTH, 8'hFF);
		wr(ADDR_CTRL, 8'h24);
		wait_cyc(4);
		rd(ADDR_CTRL);
		chk(v, 8'hE4);
		rd(ADDR_CNTH);
		chk(v, 8'h12);
		chk({7'h00, irq}, 8'h01);
		@(posedge i_core_clk) irq_en <= 1'b0;
		wait_cyc(2);
		chk({7'h00, irq}, 8'h00);
		@(posedge i_core_clk) irq_en <= 1'b1;
		wait_cyc(20);
		rd(ADDR_CTRL);
		chk(v, 8'hE4);
		wr(ADDR_CTRL, 8'h20);
		wait_cyc(2);
		chk({7'h00, irq}, 8'h00);
		rd(ADDR_CNTL);
		s = v;
		wait_cyc(20);
		rd(ADDR_CNTL);
		chk(v, s);
	endtask

	// split: low always counts and reloads, run gates high only
	task t_split();
		wr(ADDR_CNTL, 8'hFE);
		wr(ADDR_CNTH, 8'h50);
		wr(ADDR_RLL, 8'hF0);
		wr(ADDR_CTRL, 8'h08);
		wait_cyc(30);
		rd(ADDR_CTRL);
		chk(v, 8'h48);
		rd(ADDR_CNTH);
		chk(v, 8'h50);
		rd(ADDR_CNTL);
		chk({7'h00, v >= 8'hF0}, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(ADDR_CTRL, 8'h0C);
		wait_cyc(300);
		rd(ADDR_CTRL);
		chk(v, 8'hCC);
		wr(ADDR_CTRL, 8'h00);
	endtask

	// both split bytes on the shared divide-by-twelve tick
	task t_div12();
		lo_sys <= 1'b0;
		hi_sys <= 1'b0;
		wr(ADDR_CNTL, 8'h00);
		wr(ADDR_CNTH, 8'h00);
		wr(ADDR_CTRL, 8'h0C);
		wait_cyc(120);
		wr(ADDR_CTRL, 8'h00);
		rd(ADDR_CNTL);
		chk({7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
		rd(ADDR_CNTH);
		chk({7'h00, v >= 8'h09 && v <= 8'h0B}, 8'h01);
		@(posedge i_core_clk);
		lo_sys <= 1'b1;
		hi_sys <= 1'b1;
	endtask

	// capture on comparator, then on oscillator with comparator ignored
	task t_capture();
		wr(ADDR_CNTL, 8'h77);
		wr(ADDR_CNTH, 8'h66);
		wr(ADDR_CTRL, 8'h10);
		@(posedge i_core_clk) cmp1 <= 1'b1;
		wait_cyc(6);
		rd(ADDR_RLL);
		chk(v, 8'h77);
		rd(ADDR_RLH);
		chk(v, 8'h66);
		rd(ADDR_CTRL);
		chk(v, 8'h90);
		@(posedge i_core_clk) cmp1 <= 1'b0;
		wr(ADDR_CTRL, 8'h12);
		wr(ADDR_CNTL, 8'h11);
		@(posedge i_core_clk) cmp1 <= 1'b1;
		wait_cyc(6);
		rd(ADDR_RLL);
		chk(v, 8'h77);
		@(posedge i_core_clk) osc8 <= 1'b1;
		wait_cyc(6);
		rd(ADDR_RLL);
		chk(v, 8'h11);
		@(posedge i_core_clk) osc8 <= 1'b0;
		wr(ADDR_CTRL, 8'h13);
		wr(ADDR_CNTL, 8'h22);
		@(posedge i_core_clk) osc8 <= 1'b1;
		wait_cyc(6);
		rd(ADDR_RLL);
		chk(v, 8'h22);
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_reset <= 1'b0;
		t_reset();
		t_wide();
		t_split();
		t_div12();
		t_capture();
		end_sim();
	end
endmodule
